// ==== core/acf_filter_ctrl.sv ====
// acceptance filter control register for filters 24 to 27 with store selection
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns

module acf_filter_ctrl
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [acf_pkg::ACF_ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic [acf_pkg::ACF_NUM_FILT-1:0] match_hit_i,
    output logic [acf_pkg::ACF_NUM_FILT-1:0] filt_enable_o,
    output logic [acf_pkg::ACF_NUM_FILT*2-1:0] filt_mask_choice_o,
    output logic [acf_pkg::ACF_NUM_FILT*5-1:0] filt_fifo_choice_o,
    output logic store_valid_o,
    output logic [4:0] store_fifo_o,
    output logic [1:0] store_mask_o,
    output logic [1:0] store_slot_o
);
    import acf_pkg::*;

    // storage of the control word lives in the slots
    acf_slot_if slot_bus [ACF_NUM_FILT] ();

    logic [ACF_NUM_FILT-1:0] en_w;
    logic [1:0] msel_w [ACF_NUM_FILT];
    logic [4:0] fsel_w [ACF_NUM_FILT];
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic ctrl_sel;
    logic stat_sel;
    logic ctrl_wr;
    logic [31:0] nxt_rdata;

    // address decode; anything else reads as zero and writes are ignored
    assign ctrl_sel = (reg_addr_i == ACF_CTRL_OFS);
    assign stat_sel = (reg_addr_i == ACF_STAT_OFS);
    assign ctrl_wr = reg_wr_i && ctrl_sel;

    // one slot per byte lane, byte 0 is filter 24 and byte 3 is filter 27
    genvar g;
    generate
        for (g = 0; g < ACF_NUM_FILT; g++)
        begin : g_slot
            assign slot_bus[g].wr = ctrl_wr;
            assign slot_bus[g].wdata = acf_byte(reg_wdata_i, g);
            assign en_w[g] = slot_bus[g].en;
            assign msel_w[g] = slot_bus[g].msel;
            assign fsel_w[g] = slot_bus[g].fsel;
            assign ctrl_word[g*8 +: 8] = acf_pack(en_w[g], msel_w[g], fsel_w[g]);

            acf_filter_slot u_slot
            (
                .core_clk_i(core_clk_i),
                .nrst_i(nrst_i),
                .sb(slot_bus[g].slot)
            );
        end
    endgenerate

    // acceptance: a hit counts only on an enabled filter, lowest filter number wins
    logic [ACF_NUM_FILT-1:0] live_hit;
    logic any_hit;
    logic [1:0] win_slot;

    assign live_hit = match_hit_i & en_w;
    assign any_hit = |live_hit;

    // priority pick; ties between filters go to the lower number
    always_comb
    begin
        win_slot = 2'h0;
        for (int i = ACF_NUM_FILT - 1; i >= 0; i--)
        begin
            if (live_hit[i])
            begin
                win_slot = i[1:0];
            end
        end
    end

    logic [4:0] win_fsel;
    logic [1:0] win_msel;
    assign win_fsel = fsel_w[win_slot];
    assign win_msel = msel_w[win_slot];

    // store request and status history
    logic store_valid_ff;
    logic [4:0] store_fifo_ff;
    logic [1:0] store_mask_ff;
    logic [1:0] store_slot_ff;
    logic [ACF_CNT_W-1:0] accept_cnt_ff;
    logic [ACF_CNT_W-1:0] nxt_accept_cnt;

    // counter wraps; software reads differences, so a wrap is harmless
    assign nxt_accept_cnt = any_hit ? accept_cnt_ff + 8'h01 : accept_cnt_ff;

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            store_valid_ff <= 1'b0;
            store_fifo_ff <= 5'h00;
            store_mask_ff <= 2'h0;
            store_slot_ff <= 2'h0;
            accept_cnt_ff <= ACF_CNT_RST;
        end
        else
        begin
            store_valid_ff <= any_hit;
            accept_cnt_ff <= nxt_accept_cnt;
            if (any_hit)
            begin
                store_fifo_ff <= win_fsel;
                store_mask_ff <= win_msel;
                store_slot_ff <= win_slot;
            end
        end
    end

    // status word shows the last accepted message and the acceptance count
    assign stat_word = {16'h0000, accept_cnt_ff, 1'b0, store_slot_ff, store_fifo_ff};

    // read data stand only in the cycle after the read strobe
    assign nxt_rdata = !reg_rd_i ? 32'h0000_0000 :
                       ctrl_sel ? ctrl_word :
                       stat_sel ? stat_word : 32'h0000_0000;

    logic [31:0] rdata_ff;
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rdata_ff <= ACF_RDATA_RST;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // mirror the slot flops out to the receive path; these are flop outputs already
    logic [ACF_NUM_FILT*2-1:0] mask_flat;
    logic [ACF_NUM_FILT*5-1:0] fifo_flat;
    generate
        for (g = 0; g < ACF_NUM_FILT; g++)
        begin : g_flat
            assign mask_flat[g*2 +: 2] = msel_w[g];
            assign fifo_flat[g*5 +: 5] = fsel_w[g];
        end
    endgenerate

    assign reg_rdata_o = rdata_ff;
    assign filt_enable_o = en_w;
    assign filt_mask_choice_o = mask_flat;
    assign filt_fifo_choice_o = fifo_flat;
    assign store_valid_o = store_valid_ff;
    assign store_fifo_o = store_fifo_ff;
    assign store_mask_o = store_mask_ff;
    assign store_slot_o = store_slot_ff;

    // checks of the register layout, the gating and the store choice
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    a_top_byte_layout: assert property (reg_rd_i && ctrl_sel |=>
        reg_rdata_o[31] == en_w[3] && reg_rdata_o[30:29] == msel_w[3]
        && reg_rdata_o[28:24] == fsel_w[3])
        else $error("filter 27 fields misplaced in read data");
    a_third_byte_layout: assert property (reg_rd_i && ctrl_sel |=>
        reg_rdata_o[23] == en_w[2] && reg_rdata_o[22:21] == msel_w[2]
        && reg_rdata_o[20:16] == fsel_w[2])
        else $error("filter 26 fields misplaced in read data");
    a_disabled_no_store: assert property ((match_hit_i & en_w) == 4'h0 |=> !store_valid_o)
        else $error("store raised without an enabled matching filter");
    a_enabled_stores: assert property ((match_hit_i & en_w) != 4'h0 |=> store_valid_o)
        else $error("enabled matching filter did not store");
    a_mask_choice: assert property (any_hit |=> store_mask_o == msel_w[store_slot_o]
        || $past(ctrl_wr))
        else $error("store mask does not follow mask choice");
    a_fifo_choice: assert property (any_hit ##1 !$past(ctrl_wr) |->
        store_fifo_o == fsel_w[store_slot_o])
        else $error("store fifo does not follow fifo choice");
    a_enable_lock: assert property (ctrl_wr && en_w[0] |=>
        filt_fifo_choice_o[4:0] == $past(fsel_w[0]) && filt_mask_choice_o[1:0] == $past(msel_w[0]))
        else $error("enabled filter 24 fields were modified");
    a_read_one_cycle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
        else $error("read data held beyond its cycle");

    c_store_hit: cover property (any_hit ##1 store_valid_o);
    c_two_hits: cover property ((match_hit_i & en_w) == 4'hC);
    c_disable_reprogram: cover property (ctrl_wr && en_w[3] ##1 ctrl_wr && !en_w[3]);
    c_status_read: cover property (reg_rd_i && stat_sel);
endmodule

// ==== core/acf_pkg.sv ====
// shared constants, field layout and helper functions for the acceptance filter control block
package acf_pkg;

    // register map, byte addresses
    localparam int ACF_ADDR_W = 8;
    localparam logic [ACF_ADDR_W-1:0] ACF_CTRL_OFS = 8'h00;
    localparam logic [ACF_ADDR_W-1:0] ACF_STAT_OFS = 8'h04;

    // filter slots held by the control word
    localparam int ACF_NUM_FILT = 4;
    localparam int ACF_FIRST_FILT = 24;
    localparam int ACF_MSEL_W = 2;
    localparam int ACF_FSEL_W = 5;

    // field positions inside one filter byte
    localparam int ACF_EN_POS = 7;
    localparam int ACF_MSEL_LO = 5;
    localparam int ACF_FSEL_LO = 0;

    // field positions inside the status word
    localparam int ACF_STAT_FIFO_LO = 0;
    localparam int ACF_STAT_SLOT_LO = 5;
    localparam int ACF_STAT_CNT_LO = 8;
    localparam int ACF_CNT_W = 8;

    // values after reset
    localparam logic [31:0] ACF_CTRL_RST = 32'h0000_0000;
    localparam logic [7:0] ACF_BYTE_RST = 8'h00;
    localparam logic [31:0] ACF_RDATA_RST = 32'h0000_0000;
    localparam logic [ACF_CNT_W-1:0] ACF_CNT_RST = 8'h00;

    // take byte number idx out of a 32-bit word
    function automatic logic [7:0] acf_byte(input logic [31:0] word, input int idx);
        acf_byte = word[idx*8 +: 8];
    endfunction

    // build one filter byte from its fields
    function automatic logic [7:0] acf_pack(input logic en, input logic [1:0] msel,
                                            input logic [4:0] fsel);
        acf_pack = {en, msel, fsel};
    endfunction

endpackage

// ==== core/acf_slot_if.sv ====
// carrier between the register decode and one filter slot
`timescale 1ns/1ns
interface acf_slot_if;
    logic wr;
    logic [7:0] wdata;
    logic en;
    logic [1:0] msel;
    logic [4:0] fsel;

    // decode side drives the write, slot side returns its stored fields
    modport ctrl (output wr, output wdata, input en, input msel, input fsel);
    modport slot (input wr, input wdata, output en, output msel, output fsel);
endinterface

// ==== core/acf_filter_slot.sv ====
// one filter byte: enable, mask choice and fifo choice with the change lock
`timescale 1ns/1ns
module acf_filter_slot
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    acf_slot_if.slot sb
);
    import acf_pkg::*;

    logic en_ff;
    logic [1:0] msel_ff;
    logic [4:0] fsel_ff;
    logic nxt_en;
    logic fields_open;
    logic [1:0] nxt_msel;
    logic [4:0] nxt_fsel;

    // fields move only while the filter is off; a blocked write is dropped silently
    assign fields_open = sb.wr && !en_ff;
    assign nxt_en = sb.wr ? sb.wdata[ACF_EN_POS] : en_ff;
    assign nxt_msel = fields_open ? sb.wdata[ACF_MSEL_LO +: 2] : msel_ff;
    assign nxt_fsel = fields_open ? sb.wdata[ACF_FSEL_LO +: 5] : fsel_ff;

    // enable bit itself is always writable, so software can switch off and reprogram
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            en_ff <= ACF_BYTE_RST[ACF_EN_POS];
            msel_ff <= ACF_BYTE_RST[ACF_MSEL_LO +: 2];
            fsel_ff <= ACF_BYTE_RST[ACF_FSEL_LO +: 5];
        end
        else
        begin
            en_ff <= nxt_en;
            msel_ff <= nxt_msel;
            fsel_ff <= nxt_fsel;
        end
    end

    assign sb.en = en_ff;
    assign sb.msel = msel_ff;
    assign sb.fsel = fsel_ff;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    a_locked_fields: assert property (sb.wr && en_ff |=> $stable(msel_ff) && $stable(fsel_ff))
        else $error("filter fields changed while enabled");
    a_open_write: assert property (sb.wr && !en_ff |=> {msel_ff, fsel_ff} == $past(sb.wdata[6:0]))
        else $error("write to disabled filter not stored");
    c_blocked_write: cover property (sb.wr && en_ff && sb.wdata[6:0] != {msel_ff, fsel_ff});
endmodule

// ==== tb/acf_rx_model.sv ====
// receive-path stand-in that raises filter match lines on command
`timescale 1ns/1ns
module acf_rx_model
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic fire_i,
    input wire logic [3:0] hit_pat_i,
    output logic [3:0] match_hit_o
);
    // a match lasts one cycle, then the lines fall back to no match
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            match_hit_o <= 4'h0;
        else
            match_hit_o <= fire_i ? hit_pat_i : 4'h0;
    end
endmodule

// ==== tb/test_acf_filter_ctrl.sv ====
// self-checking bench for the filter control register and store selection
`timescale 1ns/1ns
module test_acf_filter_ctrl;
    import acf_pkg::*;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [ACF_ADDR_W-1:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic fire = 1'b0;
    logic [3:0] hit_pat = 4'h0;
    logic [31:0] rdata;
    logic [3:0] hit;
    logic [3:0] f_en;
    logic [7:0] f_msk;
    logic [19:0] f_fifo;
    logic st_v;
    logic [4:0] st_fifo;
    logic [1:0] st_msk;
    logic [1:0] st_slot;
    int num_errors = 0;
    int check_count = 0;

    // 10 MHz core clock
    initial
    begin
        forever #50 core_clk_i = ~core_clk_i;
    end

    acf_filter_ctrl u_acf_filter_ctrl (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .match_hit_i(hit), .filt_enable_o(f_en),
        .filt_mask_choice_o(f_msk), .filt_fifo_choice_o(f_fifo), .store_valid_o(st_v),
        .store_fifo_o(st_fifo), .store_mask_o(st_msk), .store_slot_o(st_slot));
    acf_rx_model u_acf_rx_model (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .fire_i(fire),
        .hit_pat_i(hit_pat), .match_hit_o(hit));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // one-cycle strobes, signals changed right after the edge
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk_i);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic test_reset_values();
        logic [31:0] d;
        check("enables", f_en, 0);
        bus_wr(8'h10, 32'hFFFF_FFFF);
        bus_wr(ACF_STAT_OFS, 32'hFFFF_FFFF);
        bus_rd(ACF_CTRL_OFS, d);
        check("ctrl", d, ACF_CTRL_RST);
        @(posedge core_clk_i);
        #1;
        check("rdata idle", rdata, 0);
        bus_rd(8'h10, d);
        check("unmapped", d, 0);
    endtask

    // enabled bytes take all fields in one write, disabled byte 1 keeps its enable low
    task automatic test_field_layout();
        logic [31:0] d;
        bus_wr(ACF_CTRL_OFS, 32'hFFC0_278A);
        bus_rd(ACF_CTRL_OFS, d);
        check("ctrl", d, 32'hFFC0_278A);
        check("enables", f_en, 4'hD);
        check("masks", f_msk, 8'hE4);
        check("fifos", f_fifo, 20'hF80EA);
    endtask

    task automatic test_change_lock();
        logic [31:0] d;
        bus_wr(ACF_CTRL_OFS, 32'h80A0_A780);
        bus_rd(ACF_CTRL_OFS, d);
        check("locked write", d, 32'hFFC0_A78A);
        bus_wr(ACF_CTRL_OFS, 32'h0000_0000);
        bus_rd(ACF_CTRL_OFS, d);
        check("disable only", d, 32'h7F40_270A);
    endtask

    task automatic send_hit(input logic [3:0] pat, input logic exp_v, input logic [4:0] fifo,
                            input logic [1:0] msk, input logic [1:0] slot);
        logic seen_v = 1'b0;
        @(posedge core_clk_i);
        fire <= 1'b1;
        hit_pat <= pat;
        @(posedge core_clk_i);
        fire <= 1'b0;
        for (int i = 0; i < 4 && !seen_v; i++)
        begin
            @(posedge core_clk_i);
            #1;
            seen_v = (st_v === 1'b1);
        end
        if (!exp_v)
            check("no store", seen_v, 0);
        else if (!seen_v)
        begin
            num_errors++;
            stop_test();
        end
        else
        begin
            check("fifo", st_fifo, fifo);
            check("mask", st_msk, msk);
            check("slot", st_slot, slot);
            @(posedge core_clk_i);
            #1;
            check("pulse", st_v, 0);
        end
    endtask

    // every mask code, fifo 0 and 31, lowest live filter wins, disabled hit dropped
    task automatic test_store_select();
        logic [31:0] d;
        bus_wr(ACF_CTRL_OFS, 32'h6CC5_A09F);
        send_hit(4'h1, 1'b1, 5'h1F, 2'h0, 2'h0);
        send_hit(4'h6, 1'b1, 5'h00, 2'h1, 2'h1);
        send_hit(4'h4, 1'b1, 5'h05, 2'h2, 2'h2);
        send_hit(4'h8, 1'b0, 5'h00, 2'h0, 2'h0);
        bus_wr(ACF_CTRL_OFS, 32'hECC5_A09F);
        send_hit(4'h8, 1'b1, 5'h0C, 2'h3, 2'h3);
        bus_rd(ACF_STAT_OFS, d);
        check("status", d, 32'h0000_046C);
    endtask

    initial
    begin
        repeat (3) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        test_reset_values();
        test_field_layout();
        test_change_lock();
        test_store_select();
        stop_test();
    end
endmodule
